// *** core/gpw_port_pkg.sv ***
package gpw_port_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int DATA_W = 16;
	localparam int ADDR_W = 3;
	localparam int EV_W = 4;
	localparam int VEC_W = 9;

	// ****************************************************************
	// register word addresses
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADDR_CSR = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_OUTBUF = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_INBUF = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_VECTOR = 3'h5;

	// ****************************************************************
	// control_status_reg field positions
	// ****************************************************************
	localparam int CSR_CMD0_BIT = 0;
	localparam int CSR_CMD1_BIT = 1;
	localparam int CSR_IEN_B_BIT = 5;
	localparam int CSR_IEN_A_BIT = 6;
	localparam int CSR_REQ_A_BIT = 7;
	localparam int CSR_REQ_B_BIT = 15;

	// ****************************************************************
	// interrupt status / mask bit positions
	// ****************************************************************
	localparam int EV_REQ_A = 0;
	localparam int EV_REQ_B = 1;
	localparam int EV_LOADED = 2;
	localparam int EV_TAKEN = 3;

	// ****************************************************************
	// reset values and vectors
	// ****************************************************************
	localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;
	localparam logic [VEC_W-1:0] VECTOR_BASE_DEFAULT = 9'h0c0;
	localparam logic [VEC_W-1:0] VECTOR_B_STEP = 9'h004;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_type;

	typedef struct packed {
		logic user_command_bit_1;
		logic user_command_bit_0;
		logic out_word_loaded_pulse;
		logic in_word_taken_pulse;
	} periph_ctl_type;

	typedef struct packed {
		logic req_b;
		logic req_a;
	} service_req_type;

endpackage

// *** core/req_sync.sv ***
`timescale 1ns/1ps

// two-flop synchroniser; only the second stage leaves the module
module req_sync #(
	parameter int WIDTH = 2
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// first stage feeds second stage only
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;

endmodule

// *** core/irq_unit.sv ***
`timescale 1ns/1ps

// sticky event status, mask, level interrupt and vector select
module irq_unit #(
	parameter logic [gpw_port_pkg::VEC_W-1:0] VECTOR_BASE = gpw_port_pkg::VECTOR_BASE_DEFAULT
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic [gpw_port_pkg::EV_W-1:0] event_i,
	input wire logic clear_wr_i,
	input wire logic mask_wr_i,
	input wire logic [gpw_port_pkg::EV_W-1:0] wdata_i,
	output logic [gpw_port_pkg::EV_W-1:0] status_o,
	output logic [gpw_port_pkg::EV_W-1:0] mask_o,
	output logic irq_o,
	output logic [gpw_port_pkg::VEC_W-1:0] vector_o
);
	import gpw_port_pkg::*;

	logic [EV_W-1:0] status_r;
	logic [EV_W-1:0] status_nxt;
	logic [EV_W-1:0] mask_r;
	logic [VEC_W-1:0] vector_r;
	logic [VEC_W-1:0] vector_nxt;
	logic [EV_W-1:0] pending;

	// write one to clear; a new event in the same cycle wins
	assign status_nxt = (status_r & ~(clear_wr_i ? wdata_i : EV_RST)) | event_i;
	assign pending = status_r & mask_r;
	// request a is served first, b gets the vector four above
	assign vector_nxt = pending[EV_REQ_A] ? VECTOR_BASE :
		pending[EV_REQ_B] ? VECTOR_BASE + VECTOR_B_STEP : VECTOR_BASE;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			status_r <= EV_RST;
			mask_r <= EV_RST;
			vector_r <= VECTOR_BASE;
		end else begin
			status_r <= status_nxt;
			vector_r <= vector_nxt;
			if (mask_wr_i) begin
				mask_r <= wdata_i;
			end
		end
	end

	assign status_o = status_r;
	assign mask_o = mask_r;
	assign irq_o = |pending;
	assign vector_o = vector_r;

endmodule

// *** core/general_parallel_word_port.sv ***
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps

module general_parallel_word_port #(
	parameter logic [gpw_port_pkg::VEC_W-1:0] VECTOR_BASE = gpw_port_pkg::VECTOR_BASE_DEFAULT
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire gpw_port_pkg::reg_req_type reg_req_i,
	output logic [gpw_port_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic [gpw_port_pkg::DATA_W-1:0] parallel_in_lines_i,
	input wire gpw_port_pkg::service_req_type service_req_i,
	output logic [gpw_port_pkg::DATA_W-1:0] parallel_out_lines_o,
	output gpw_port_pkg::periph_ctl_type periph_ctl_o,
	output logic irq_o,
	output logic [gpw_port_pkg::VEC_W-1:0] irq_vector_o
);
	import gpw_port_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [DATA_W-1:0] output_word_buffer_r;
	logic [DATA_W-1:0] output_word_buffer_nxt;
	logic user_command_bit_0_r;
	logic user_command_bit_1_r;
	logic irq_enable_a_r;
	logic irq_enable_b_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic loaded_pulse_r;
	logic taken_pulse_r;
	logic [1:0] req_async;
	logic [1:0] req_sync;
	logic req_a_s;
	logic req_b_s;
	logic arm_a_r;
	logic arm_b_r;
	logic arm_a;
	logic arm_b;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_mask;
	logic [VEC_W-1:0] vector;
	logic [DATA_W-1:0] control_status_reg;
	logic sel_csr;
	logic sel_outbuf;
	logic sel_inbuf;
	logic sel_stat;
	logic sel_mask;
	logic sel_vector;
	logic wr_csr;
	logic wr_outbuf;
	logic rd_inbuf;
	logic wr_stat;
	logic wr_mask;

	// ****************************************************************
	// helpers
	// ****************************************************************

	// zero-extend an event-width field to a data word
	function automatic logic [DATA_W-1:0] ev_word(input logic [EV_W-1:0] v);
		logic [DATA_W-1:0] w;
		w = '0;
		w[EV_W-1:0] = v;
		return w;
	endfunction

	// zero-extend a vector to a data word
	function automatic logic [DATA_W-1:0] vec_word(input logic [VEC_W-1:0] v);
		logic [DATA_W-1:0] w;
		w = '0;
		w[VEC_W-1:0] = v;
		return w;
	endfunction

	// ****************************************************************
	// address decode
	// ****************************************************************

	// one select per mapped word
	assign sel_csr = (reg_req_i.addr == ADDR_CSR);
	assign sel_outbuf = (reg_req_i.addr == ADDR_OUTBUF);
	assign sel_inbuf = (reg_req_i.addr == ADDR_INBUF);
	assign sel_stat = (reg_req_i.addr == ADDR_IRQ_STAT);
	assign sel_mask = (reg_req_i.addr == ADDR_IRQ_MASK);
	assign sel_vector = (reg_req_i.addr == ADDR_VECTOR);

	// qualified strobes
	assign wr_csr = reg_req_i.wr & sel_csr;
	assign wr_outbuf = reg_req_i.wr & sel_outbuf;
	assign rd_inbuf = reg_req_i.rd & sel_inbuf;
	assign wr_stat = reg_req_i.wr & sel_stat;
	assign wr_mask = reg_req_i.wr & sel_mask;

	// ****************************************************************
	// service request inputs
	// ****************************************************************

	// far end edge: request lines are levels raised by the peripheral
	assign req_async = {service_req_i.req_b, service_req_i.req_a};

	// sync requests: two flops before any use
	req_sync #(
		.WIDTH(2)
	) u_req_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(req_async),
		.sync_o(req_sync)
	);

	assign req_a_s = req_sync[0];
	assign req_b_s = req_sync[1];

	// enable gates interrupt: request and enable must both be true
	assign arm_a = req_a_s & irq_enable_a_r;
	assign arm_b = req_b_s & irq_enable_b_r;

	// remember the armed levels so one request raises one event
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			arm_a_r <= 1'b0;
			arm_b_r <= 1'b0;
		end else begin
			arm_a_r <= arm_a;
			arm_b_r <= arm_b;
		end
	end

	// paired interrupt: a far command bit arrives here as a request edge
	assign events[EV_REQ_A] = arm_a & ~arm_a_r;
	assign events[EV_REQ_B] = arm_b & ~arm_b_r;
	assign events[EV_LOADED] = loaded_pulse_r;
	assign events[EV_TAKEN] = taken_pulse_r;

	// ****************************************************************
	// control word
	// ****************************************************************

	// four storage bits: only commands and enables are stored
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			user_command_bit_0_r <= 1'b0;
			user_command_bit_1_r <= 1'b0;
			irq_enable_a_r <= 1'b0;
			irq_enable_b_r <= 1'b0;
		end else if (wr_csr) begin
			// command flops: bits 0 and 1 loaded from the host
			user_command_bit_0_r <= reg_req_i.wdata[CSR_CMD0_BIT];
			user_command_bit_1_r <= reg_req_i.wdata[CSR_CMD1_BIT];
			irq_enable_a_r <= reg_req_i.wdata[CSR_IEN_A_BIT];
			irq_enable_b_r <= reg_req_i.wdata[CSR_IEN_B_BIT];
		end
	end

	// read-only requests: bits 7 and 15 mirror synced requests
	always_comb begin
		control_status_reg = '0;
		control_status_reg[CSR_CMD0_BIT] = user_command_bit_0_r;
		control_status_reg[CSR_CMD1_BIT] = user_command_bit_1_r;
		control_status_reg[CSR_IEN_B_BIT] = irq_enable_b_r;
		control_status_reg[CSR_IEN_A_BIT] = irq_enable_a_r;
		control_status_reg[CSR_REQ_A_BIT] = req_a_s;
		control_status_reg[CSR_REQ_B_BIT] = req_b_s;
	end

	// ****************************************************************
	// output word buffer
	// ****************************************************************

	// output buffer: full word loaded on a host write
	assign output_word_buffer_nxt = wr_outbuf ? reg_req_i.wdata : output_word_buffer_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			output_word_buffer_r <= WORD_RST;
		end else begin
			output_word_buffer_r <= output_word_buffer_nxt;
		end
	end

	// ****************************************************************
	// peripheral pulses
	// ****************************************************************

	// loaded pulse / taken pulse / one clock each
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			loaded_pulse_r <= 1'b0;
			taken_pulse_r <= 1'b0;
		end else begin
			loaded_pulse_r <= wr_outbuf;
			taken_pulse_r <= rd_inbuf;
		end
	end

	// ****************************************************************
	// interrupt status, mask and vector
	// ****************************************************************

	// vector select: a before b, b four above
	irq_unit #(
		.VECTOR_BASE(VECTOR_BASE)
	) u_irq_unit (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.event_i(events),
		.clear_wr_i(wr_stat),
		.mask_wr_i(wr_mask),
		.wdata_i(reg_req_i.wdata[EV_W-1:0]),
		.status_o(irq_status),
		.mask_o(irq_mask),
		.irq_o(irq_o),
		.vector_o(vector)
	);

	// ****************************************************************
	// read data path
	// ****************************************************************

	// read mux; unmapped words read zero, input lines sampled at the read
	always_comb begin
		rdata_nxt = '0;
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				ADDR_CSR: begin
					rdata_nxt = control_status_reg;
				end
				ADDR_OUTBUF: begin
					rdata_nxt = output_word_buffer_r;
				end
				// far word read: in lines carry the far output buffer
				ADDR_INBUF: begin
					rdata_nxt = parallel_in_lines_i;
				end
				ADDR_IRQ_STAT: begin
					rdata_nxt = ev_word(irq_status);
				end
				ADDR_IRQ_MASK: begin
					rdata_nxt = ev_word(irq_mask);
				end
				ADDR_VECTOR: begin
					rdata_nxt = vec_word(vector);
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_r <= WORD_RST;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************

	// bit for bit: out lines map straight onto the far in lines
	assign parallel_out_lines_o = output_word_buffer_r;
	// start level / direction: command flops drive the lines
	assign periph_ctl_o.user_command_bit_0 = user_command_bit_0_r;
	assign periph_ctl_o.user_command_bit_1 = user_command_bit_1_r;
	assign periph_ctl_o.out_word_loaded_pulse = loaded_pulse_r;
	assign periph_ctl_o.in_word_taken_pulse = taken_pulse_r;
	assign reg_rdata_o = rdata_r;
	assign irq_vector_o = vector;

endmodule

// *** verif/general_parallel_word_port_properties.sv ***
`timescale 1ns/1ps

// watches the port's pulses, buffers and readback from its pins
module general_parallel_word_port_properties
	import gpw_port_pkg::*;
#(
	parameter logic [gpw_port_pkg::VEC_W-1:0] VECTOR_BASE = gpw_port_pkg::VECTOR_BASE_DEFAULT
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire gpw_port_pkg::reg_req_type reg_req_i,
	input wire logic [gpw_port_pkg::DATA_W-1:0] reg_rdata_o,
	input wire logic [gpw_port_pkg::DATA_W-1:0] parallel_in_lines_i,
	input wire gpw_port_pkg::service_req_type service_req_i,
	input wire logic [gpw_port_pkg::DATA_W-1:0] parallel_out_lines_o,
	input wire gpw_port_pkg::periph_ctl_type periph_ctl_o,
	input wire logic irq_o,
	input wire logic [gpw_port_pkg::VEC_W-1:0] irq_vector_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// access decode
	wire wr_out = reg_req_i.wr && reg_req_i.addr == ADDR_OUTBUF;
	wire rd_in = reg_req_i.rd && reg_req_i.addr == ADDR_INBUF;
	wire wr_csr = reg_req_i.wr && reg_req_i.addr == ADDR_CSR;
	wire rd_csr = reg_req_i.rd && reg_req_i.addr == ADDR_CSR;

	a_loaded_pulse: assert property (wr_out |=> periph_ctl_o.out_word_loaded_pulse)
		else $error("loaded pulse missing");
	a_loaded_cause: assert property (periph_ctl_o.out_word_loaded_pulse |-> $past(wr_out))
		else $error("loaded pulse without write");
	a_taken_pulse: assert property (rd_in |=> periph_ctl_o.in_word_taken_pulse &&
		reg_rdata_o == $past(parallel_in_lines_i)) else $error("taken pulse or word wrong");
	a_taken_cause: assert property (periph_ctl_o.in_word_taken_pulse |-> $past(rd_in))
		else $error("taken pulse without read");
	a_outbuf_load: assert property (wr_out |=> parallel_out_lines_o == $past(reg_req_i.wdata))
		else $error("out lines not loaded");
	a_outbuf_hold: assert property (!wr_out |=> $stable(parallel_out_lines_o))
		else $error("out lines moved");
	a_cmd_bits: assert property (wr_csr |=>
		periph_ctl_o.user_command_bit_0 == $past(reg_req_i.wdata[CSR_CMD0_BIT]) &&
		periph_ctl_o.user_command_bit_1 == $past(reg_req_i.wdata[CSR_CMD1_BIT]))
		else $error("command lines wrong");
	a_csr_unused: assert property (rd_csr |=> reg_rdata_o[14:8] == 7'h00 &&
		reg_rdata_o[4:2] == 3'h0) else $error("unused control bits set");
	a_req_readback: assert property (rd_csr && $past(rst_n_i, 4) && $stable(service_req_i) &&
		$past(service_req_i) == $past(service_req_i, 3) && $past(service_req_i, 2) == service_req_i
		|=> reg_rdata_o[CSR_REQ_A_BIT] == $past(service_req_i.req_a) &&
		reg_rdata_o[CSR_REQ_B_BIT] == $past(service_req_i.req_b)) else $error("request bits wrong");
	a_vector_pair: assert property (irq_vector_o == VECTOR_BASE ||
		irq_vector_o == VECTOR_BASE + VECTOR_B_STEP) else $error("vector off base");
endmodule

bind general_parallel_word_port general_parallel_word_port_properties #(
	.VECTOR_BASE(VECTOR_BASE)
) i_props (
	.core_clk_i(core_clk_i),
	.rst_n_i(rst_n_i),
	.reg_req_i(reg_req_i),
	.reg_rdata_o(reg_rdata_o),
	.parallel_in_lines_i(parallel_in_lines_i),
	.service_req_i(service_req_i),
	.parallel_out_lines_o(parallel_out_lines_o),
	.periph_ctl_o(periph_ctl_o),
	.irq_o(irq_o),
	.irq_vector_o(irq_vector_o)
);

// *** verif/periph_model.sv ***
`timescale 1ns/1ps

// user peripheral: takes words while started, then asks for service
module periph_model
	import gpw_port_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire gpw_port_pkg::periph_ctl_type ctl_i,
	input wire logic [gpw_port_pkg::DATA_W-1:0] out_lines_i,
	output gpw_port_pkg::service_req_type req_o,
	output logic [gpw_port_pkg::DATA_W-1:0] in_lines_o
);
	logic [DATA_W-1:0] word_r;

	// complement back, so a bare loop-back cannot pass
	assign in_lines_o = ~word_r;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			word_r <= 16'h0000;
			req_o <= '0;
		end else begin
			req_o.req_b <= ctl_i.user_command_bit_1;
			if (ctl_i.out_word_loaded_pulse && ctl_i.user_command_bit_0) begin
				word_r <= out_lines_i;
				req_o.req_a <= 1'b1;
			end else if (ctl_i.in_word_taken_pulse) begin
				req_o.req_a <= 1'b0;
			end
		end
	end
endmodule

// *** verif/general_parallel_word_port_tb.sv ***
`timescale 1ns/1ps

module general_parallel_word_port_tb;
	import gpw_port_pkg::*;
	logic core_clk_i;
	logic rst_n_i;
	reg_req_type reg_req_i;
	logic [DATA_W-1:0] reg_rdata_o;
	logic [DATA_W-1:0] in_lines;
	logic [DATA_W-1:0] out_lines;
	service_req_type service_req;
	periph_ctl_type ctl;
	logic irq_o;
	logic [VEC_W-1:0] irq_vector_o;
	int num_errors = 0;
	int checks_done = 0;

	general_parallel_word_port i_dut (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.reg_req_i(reg_req_i),
		.reg_rdata_o(reg_rdata_o),
		.parallel_in_lines_i(in_lines),
		.service_req_i(service_req),
		.parallel_out_lines_o(out_lines),
		.periph_ctl_o(ctl),
		.irq_o(irq_o),
		.irq_vector_o(irq_vector_o)
	);

	periph_model i_periph (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ctl_i(ctl),
		.out_lines_i(out_lines),
		.req_o(service_req),
		.in_lines_o(in_lines)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	// ****************************************************************
	// bus and compare helpers
	// ****************************************************************
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d);
		reg_req_i <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge core_clk_i);
		#1;
	endtask

	task automatic idle(input int n);
		reg_req_i <= '0;
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
		idle(1);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp, input string what);
		bus(1'b0, a, 16'h0000);
		check(what, exp, reg_rdata_o);
		idle(1);
	endtask

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset;
		rd(ADDR_CSR, 16'h0000, "csr at reset");
		rd(ADDR_OUTBUF, 16'h0000, "out buffer at reset");
		rd(ADDR_IRQ_MASK, 16'h0000, "mask at reset");
		rd(ADDR_VECTOR, 16'h00c0, "idle vector");
		wr(3'h7, 16'hffff);
		rd(3'h7, 16'h0000, "unmapped read");
		wr(ADDR_VECTOR, 16'hffff);
		rd(ADDR_VECTOR, 16'h00c0, "vector after write");
		$display("reset test done");
	endtask

	task automatic t_csr;
		wr(ADDR_CSR, 16'hffff);
		check("command lines", 16'h0003, {14'h0, ctl.user_command_bit_1, ctl.user_command_bit_0});
		idle(4);
		rd(ADDR_CSR, 16'h8063, "csr all ones");
		wr(ADDR_CSR, 16'h0000);
		idle(4);
		rd(ADDR_CSR, 16'h0000, "csr cleared");
		check("command lines off", 16'h0000, {14'h0, ctl.user_command_bit_1, ctl.user_command_bit_0});
		$display("control word test done");
	endtask

	task automatic t_words;
		wr(ADDR_IRQ_STAT, 16'h000f);
		wr(ADDR_IRQ_MASK, 16'h0003);
		rd(ADDR_IRQ_MASK, 16'h0003, "mask");
		wr(ADDR_CSR, 16'h0001);
		bus(1'b1, ADDR_OUTBUF, 16'ha5c3);
		check("loaded pulse 1", 16'h0001, {15'h0, ctl.out_word_loaded_pulse});
		check("out lines 1", 16'ha5c3, out_lines);
		bus(1'b1, ADDR_OUTBUF, 16'h3c5a);
		check("loaded pulse 2", 16'h0001, {15'h0, ctl.out_word_loaded_pulse});
		check("out lines 2", 16'h3c5a, out_lines);
		idle(1);
		check("loaded pulse end", 16'h0000, {15'h0, ctl.out_word_loaded_pulse});
		idle(4);
		check("irq while disabled", 16'h0000, {15'h0, irq_o});
		rd(ADDR_CSR, 16'h0081, "request a as flag");
		wr(ADDR_CSR, 16'h0041);
		idle(3);
		check("irq a", 16'h0001, {15'h0, irq_o});
		check("vector a", 16'h00c0, {7'h0, irq_vector_o});
		rd(ADDR_IRQ_STAT, 16'h0005, "status a");
		bus(1'b0, ADDR_INBUF, 16'h0000);
		check("input word", 16'hc3a5, reg_rdata_o);
		check("taken pulse", 16'h0001, {15'h0, ctl.in_word_taken_pulse});
		idle(4);
		check("irq sticky", 16'h0001, {15'h0, irq_o});
		wr(ADDR_IRQ_STAT, 16'h000f);
		check("irq cleared", 16'h0000, {15'h0, irq_o});
		$display("word transfer test done");
	endtask

	task automatic t_req_b;
		wr(ADDR_CSR, 16'h0022);
		idle(5);
		check("irq b", 16'h0001, {15'h0, irq_o});
		check("vector b", 16'h00c4, {7'h0, irq_vector_o});
		rd(ADDR_CSR, 16'h8022, "request b");
		wr(ADDR_IRQ_STAT, 16'h0002);
		idle(2);
		check("irq b cleared", 16'h0000, {15'h0, irq_o});
		wr(ADDR_CSR, 16'h0000);
		$display("request b test done");
	endtask

	// watchdog against a hang
	initial begin
		repeat (2000) @(posedge core_clk_i);
		num_errors++;
		wrap_up();
	end

	initial begin
		rst_n_i = 1'b0;
		reg_req_i = '0;
		repeat (8) @(posedge core_clk_i);
		#1;
		rst_n_i <= 1'b1;
		idle(1);
		t_reset();
		t_csr();
		t_words();
		t_req_b();
		wrap_up();
	end
endmodule
